// *** hdl/ccd_top.v ***
// Converter control, diagnostics and setup registers behind the serial register port
// Summary of operation
// - Control register picks full, mid or low power; core runs at that level.
// - Control mode field picks continuous, single, standby, power-down or calibration.
// - Control register holds clock source select and internal reference enable.
// - Reference source comes from each setup's configuration register, not control.
// - Control register holds status-append and continuous readout interface options.
// - Control register is 16-bit, read/write, resets to zero; options in upper byte.
// - Flag register is 24-bit read-only, resets zero; bits 19:16 core faults, 23:20 zero.
// - Enable register is 24-bit read/write; only ignored-access enable set at reset.
// - Eight-bit read-only master clock tally, reset to zero.
// - Finished calibration overwrites offset or gain of the selected channel's setup.
// - Channel register top bit enables that channel's input pair for conversion.
// - In continuous mode, enabled channels convert in ascending order, wrapping to the lowest, forever.
// - Each channel picks any of eight setups; correction applies per setup.
// - Flag shows only while enabled; enabled flags OR into status error bit.
// - Sequencer skips channels whose enable bit is clear.
// - Writes during power-up or busy calibration are ignored and flagged.
`timescale 1ns/1ns
`include "ccd_defs.vh"
module ccd_top #(
	parameter SETUPS = 8,
	parameter BOOT_CYCLES = `CCD_BOOT_CYCLES,
	parameter [23:0] GAIN_RESET = `CCD_GAIN_RST
) (
	// System
	input wire MCLK,
	input wire RST_N,
	// Serial register port
	input wire SCLK,
	input wire CS_N,
	input wire DIN,
	output reg DOUT,
	output reg DOUT_OE,
	// Core settings
	output wire [1:0] POWER_LEVEL,
	output wire [3:0] OP_MODE,
	output wire [1:0] CLK_SOURCE,
	output wire REF_ENABLE,
	output wire CS_GATE_EN,
	output wire APPEND_STATUS,
	output wire CONT_READOUT,
	output wire OUTPUT_READY_DELAY,
	// Conversion request
	output reg CONV_START,
	output reg [3:0] CONV_MODE,
	output reg [3:0] CONV_CHANNEL,
	output reg [4:0] CONV_POS,
	output reg [4:0] CONV_NEG,
	output reg [2:0] CONV_SETUP,
	output reg [1:0] CONV_REF_SOURCE,
	output reg [23:0] CONV_OFFSET,
	output reg [23:0] CONV_GAIN,
	input wire CONV_DONE,
	input wire [23:0] CAL_VALUE,
	// Diagnostics
	input wire [23:0] FAULT_IN,
	output reg ERROR_FLAG
);
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;
	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_CTRL = 3'h1;
	localparam [2:0] SEL_EN = 3'h2;
	localparam [2:0] SEL_CHAN = 3'h3;
	localparam [2:0] SEL_CFG = 3'h4;
	localparam [2:0] SEL_OFS = 3'h5;
	localparam [2:0] SEL_GAIN = 3'h6;

	wire sp_rise;
	wire sp_fall;
	wire sp_din;
	wire sp_cs;
	wire sp_end;
	reg [15:0] ctrl_reg;
	reg [23:0] en_reg;
	reg [23:0] flag_reg;
	reg [7:0] tally_reg;
	reg [3:0] sticky_reg;
	reg [15:0] boot_cnt_reg;
	reg boot_done_reg;
	reg [6:0] cmd_reg;
	reg data_phase_reg;
	reg [4:0] bit_cnt_reg;
	reg [2:0] frame_bits_reg;
	reg [5:0] addr_reg;
	reg rd_reg;
	reg [4:0] len_reg;
	reg [22:0] rx_reg;
	reg [23:0] tx_reg;
	reg state_reg;
	reg [3:0] run_mode_reg;
	reg [2:0] run_setup_reg;
	reg rdy_n_reg;
	reg [16*SETUPS-1:0] cfg_all;
	reg [24*SETUPS-1:0] ofs_all;
	reg [24*SETUPS-1:0] gain_all;

	wire [7:0] cmd_full;
	wire [5:0] dec_addr;
	wire [5:0] chan_off;
	wire [5:0] cfg_off;
	wire [5:0] ofs_off;
	wire [5:0] gain_off;
	wire [23:0] wdata;
	wire [15:0] seq_rd;
	wire [15:0] cur_word;
	wire [3:0] cur_chan;
	wire any_en;
	wire [2:0] cur_setup;
	wire [3:0] mode;
	wire cal_busy;
	wire last_bit;
	wire write_try;
	wire write_ok;
	wire cmd_done;
	wire mode_ok;
	wire startable;
	wire skip;
	wire done_ev;
	wire advance;
	wire to_idle;
	wire cal_ofs_we;
	wire cal_gain_we;
	wire [3:0] sticky_set;
	wire [3:0] sticky_clr;
	wire [23:0] raw_flags;
	wire [23:0] en_mask;
	wire [23:0] vis_flags;
	reg [23:0] dec_val;
	reg [4:0] dec_len;
	reg dec_map;
	reg [2:0] dec_sel;

	ccd_serial_port u_port (
		.clk(MCLK),
		.rst_n(RST_N),
		.sclk(SCLK),
		.cs_n(CS_N),
		.din(DIN),
		.rise(sp_rise),
		.fall(sp_fall),
		.din_f(sp_din),
		.cs_act(sp_cs),
		.frame_end(sp_end)
	);

	ccd_sequencer #(
		.CHANNELS(16)
	) u_seq (
		.clk(MCLK),
		.rst_n(RST_N),
		.wr_en(write_ok && dec_sel == SEL_CHAN),
		.wr_idx(chan_off[3:0]),
		.wr_data(wdata[15:0]),
		.rd_idx(chan_off[3:0]),
		.rd_data(seq_rd),
		.advance(advance),
		.cur_chan(cur_chan),
		.cur_word(cur_word),
		.any_en(any_en)
	);

	// Settings straight from the control register
	assign POWER_LEVEL = ctrl_reg[`CCD_CTL_POWER_LO +: 2];
	assign OP_MODE = ctrl_reg[`CCD_CTL_MODE_LO +: 4];
	assign CLK_SOURCE = ctrl_reg[`CCD_CTL_CLK_LO +: 2];
	assign REF_ENABLE = ctrl_reg[`CCD_CTL_REF_EN];
	assign CS_GATE_EN = ctrl_reg[`CCD_CTL_CS_EN];
	assign APPEND_STATUS = ctrl_reg[`CCD_CTL_DATA_STATUS];
	assign CONT_READOUT = ctrl_reg[`CCD_CTL_CONTINUOUS_READOUT];
	assign OUTPUT_READY_DELAY = ctrl_reg[`CCD_CTL_RDY_DEL];
	assign mode = ctrl_reg[`CCD_CTL_MODE_LO +: 4];

	// Address decode
	assign cmd_full = {cmd_reg, sp_din};
	assign dec_addr = data_phase_reg ? addr_reg : cmd_full[5:0];
	assign chan_off = dec_addr - `CCD_ADDR_CHAN_BASE;
	assign cfg_off = dec_addr - `CCD_ADDR_CONFIG_BASE;
	assign ofs_off = dec_addr - `CCD_ADDR_OFFSET_BASE;
	assign gain_off = dec_addr - `CCD_ADDR_GAIN_BASE;
	always @* begin
		dec_val = 24'h00_0000;
		dec_len = 5'd8;
		dec_map = 1'b1;
		dec_sel = SEL_NONE;
		if (dec_addr == `CCD_ADDR_STATUS) begin
			dec_val = {16'h0000, rdy_n_reg, ERROR_FLAG, 2'b00, cur_chan};
		end else if (dec_addr == `CCD_ADDR_CONTROL) begin
			dec_val = {8'h00, ctrl_reg};
			dec_len = 5'd16;
			dec_sel = SEL_CTRL;
		end else if (dec_addr == `CCD_ADDR_FLAGS) begin
			dec_val = flag_reg;
			dec_len = 5'd24;
		end else if (dec_addr == `CCD_ADDR_ENABLES) begin
			dec_val = en_reg;
			dec_len = 5'd24;
			dec_sel = SEL_EN;
		end else if (dec_addr == `CCD_ADDR_TALLY) begin
			dec_val = {16'h0000, tally_reg};
		end else if (dec_addr >= `CCD_ADDR_CHAN_BASE && dec_addr <= `CCD_ADDR_CHAN_LAST) begin
			dec_val = {8'h00, seq_rd};
			dec_len = 5'd16;
			dec_sel = SEL_CHAN;
		end else if (dec_addr >= `CCD_ADDR_CONFIG_BASE && dec_addr <= `CCD_ADDR_CONFIG_LAST) begin
			dec_val = {8'h00, cfg_all[16*cfg_off[2:0] +: 16]};
			dec_len = 5'd16;
			dec_sel = SEL_CFG;
		end else if (dec_addr >= `CCD_ADDR_OFFSET_BASE && dec_addr <= `CCD_ADDR_OFFSET_LAST) begin
			dec_val = ofs_all[24*ofs_off[2:0] +: 24];
			dec_len = 5'd24;
			dec_sel = SEL_OFS;
		end else if (dec_addr >= `CCD_ADDR_GAIN_BASE && dec_addr <= `CCD_ADDR_GAIN_LAST) begin
			dec_val = gain_all[24*gain_off[2:0] +: 24];
			dec_len = 5'd24;
			dec_sel = SEL_GAIN;
		end else begin
			dec_map = 1'b0;
		end
	end

	// Serial framing: command byte, then data of the register's width
	assign wdata = {rx_reg, sp_din};
	assign last_bit = sp_rise && sp_cs && data_phase_reg && bit_cnt_reg == len_reg - 5'd1;
	assign write_try = last_bit && !rd_reg;
	assign cal_busy = state_reg == ST_BUSY && run_mode_reg >= `CCD_MODE_INT_ZERO;
	assign write_ok = write_try && dec_sel != SEL_NONE && boot_done_reg && !cal_busy;
	assign cmd_done = sp_rise && sp_cs && !data_phase_reg && bit_cnt_reg == 5'd7 && !cmd_full[7];
	always @(posedge MCLK) begin
		if (!RST_N) begin
			cmd_reg <= 7'h00;
			data_phase_reg <= 1'b0;
			bit_cnt_reg <= 5'd0;
			frame_bits_reg <= 3'd0;
			addr_reg <= 6'h00;
			rd_reg <= 1'b0;
			len_reg <= 5'd8;
			rx_reg <= 23'h00_0000;
			tx_reg <= 24'h00_0000;
			DOUT <= 1'b0;
			DOUT_OE <= 1'b0;
		end else begin
			DOUT_OE <= sp_cs;
			if (sp_end || !sp_cs) begin
				data_phase_reg <= 1'b0;
				bit_cnt_reg <= 5'd0;
				frame_bits_reg <= 3'd0;
			end else if (sp_rise) begin
				frame_bits_reg <= frame_bits_reg + 3'd1;
				if (!data_phase_reg) begin
					cmd_reg <= cmd_full[6:0];
					if (bit_cnt_reg == 5'd7) begin
						bit_cnt_reg <= 5'd0;
						addr_reg <= cmd_full[5:0];
						rd_reg <= cmd_full[6];
						len_reg <= dec_len;
						data_phase_reg <= !cmd_full[7];
						tx_reg <= dec_val << (5'd24 - dec_len);
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 5'd1;
					end
				end else begin
					rx_reg <= wdata[22:0];
					if (last_bit) begin
						data_phase_reg <= 1'b0;
						bit_cnt_reg <= 5'd0;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 5'd1;
					end
				end
			end else if (sp_fall && data_phase_reg && rd_reg) begin
				DOUT <= tx_reg[23];
				tx_reg <= {tx_reg[22:0], 1'b0};
			end
		end
	end

	// Power-up window in which writes are refused
	always @(posedge MCLK) begin
		if (!RST_N) begin
			boot_cnt_reg <= 16'h0000;
			boot_done_reg <= 1'b0;
		end else if (!boot_done_reg) begin
			boot_cnt_reg <= boot_cnt_reg + 16'h0001;
			boot_done_reg <= boot_cnt_reg == BOOT_CYCLES[15:0] - 16'h0001;
		end
	end

	// Control and enable registers
	assign to_idle = done_ev && run_mode_reg != `CCD_MODE_CONT;
	always @(posedge MCLK) begin
		if (!RST_N) begin
			ctrl_reg <= `CCD_CONTROL_RST;
			en_reg <= `CCD_ENABLES_RST;
		end else begin
			if (write_ok && dec_sel == SEL_CTRL) begin
				ctrl_reg <= wdata[15:0] & `CCD_CONTROL_WMASK;
			end else if (to_idle) begin
				ctrl_reg[`CCD_CTL_MODE_LO +: 4] <= `CCD_MODE_IDLE;
			end
			if (write_ok && dec_sel == SEL_EN) begin
				en_reg <= wdata & `CCD_ENABLES_WMASK;
			end
		end
	end

	// Conversion and calibration sequencing
	assign mode_ok = mode == `CCD_MODE_CONT || mode == `CCD_MODE_SINGLE || mode >= `CCD_MODE_INT_ZERO;
	assign startable = state_reg == ST_IDLE && boot_done_reg && any_en && mode_ok && mode <= `CCD_MODE_SYS_FULL;
	assign skip = startable && !cur_word[`CCD_CHAN_EN];
	assign done_ev = state_reg == ST_BUSY && CONV_DONE;
	assign advance = skip || (done_ev && run_mode_reg == `CCD_MODE_CONT);
	assign cur_setup = cur_word[`CCD_CHAN_SETUP_LO +: 3];
	assign cal_ofs_we = done_ev && (run_mode_reg == `CCD_MODE_INT_ZERO || run_mode_reg == `CCD_MODE_SYS_ZERO);
	assign cal_gain_we = done_ev && (run_mode_reg == `CCD_MODE_INT_FULL || run_mode_reg == `CCD_MODE_SYS_FULL);
	always @(posedge MCLK) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			run_mode_reg <= `CCD_MODE_IDLE;
			run_setup_reg <= 3'h0;
			rdy_n_reg <= 1'b1;
			CONV_START <= 1'b0;
			CONV_MODE <= `CCD_MODE_IDLE;
			CONV_CHANNEL <= 4'h0;
			CONV_POS <= 5'h00;
			CONV_NEG <= 5'h00;
			CONV_SETUP <= 3'h0;
			CONV_REF_SOURCE <= 2'h0;
			CONV_OFFSET <= `CCD_OFFSET_RST;
			CONV_GAIN <= GAIN_RESET;
		end else begin
			CONV_START <= 1'b0;
			if (startable && cur_word[`CCD_CHAN_EN]) begin
				state_reg <= ST_BUSY;
				run_mode_reg <= mode;
				run_setup_reg <= cur_setup;
				rdy_n_reg <= 1'b1;
				CONV_START <= 1'b1;
				CONV_MODE <= mode;
				CONV_CHANNEL <= cur_chan;
				CONV_POS <= cur_word[9:5];
				CONV_NEG <= cur_word[4:0];
				CONV_SETUP <= cur_setup;
				CONV_REF_SOURCE <= cfg_all[16*cur_setup+`CCD_CFG_REF_LO +: 2];
				CONV_OFFSET <= ofs_all[24*cur_setup +: 24];
				CONV_GAIN <= gain_all[24*cur_setup +: 24];
			end else if (done_ev) begin
				state_reg <= ST_IDLE;
				if (run_mode_reg < `CCD_MODE_INT_ZERO) begin
					rdy_n_reg <= 1'b0;
				end
			end
		end
	end

	// Per-setup configuration, offset and gain
	genvar g;
	generate
		for (g = 0; g < SETUPS; g = g + 1) begin : g_setup
			localparam [2:0] IDX = g;
			always @(posedge MCLK) begin
				if (!RST_N) begin
					cfg_all[16*g +: 16] <= `CCD_CONFIG_RST;
					ofs_all[24*g +: 24] <= `CCD_OFFSET_RST;
					gain_all[24*g +: 24] <= GAIN_RESET;
				end else begin
					if (write_ok && dec_sel == SEL_CFG && cfg_off[2:0] == IDX) begin
						cfg_all[16*g +: 16] <= wdata[15:0] & `CCD_CONFIG_WMASK;
					end
					if (cal_ofs_we && run_setup_reg == IDX) begin
						ofs_all[24*g +: 24] <= CAL_VALUE;
					end else if (write_ok && dec_sel == SEL_OFS && ofs_off[2:0] == IDX) begin
						ofs_all[24*g +: 24] <= wdata;
					end
					if (cal_gain_we && run_setup_reg == IDX) begin
						gain_all[24*g +: 24] <= CAL_VALUE;
					end else if (write_ok && dec_sel == SEL_GAIN && gain_off[2:0] == IDX) begin
						gain_all[24*g +: 24] <= wdata;
					end
				end
			end
		end
	endgenerate

	// Diagnostics: sticky serial faults, enable gating, error summary
	assign sticky_set[3] = write_try && (!boot_done_reg || cal_busy);
	assign sticky_set[2] = sp_end && frame_bits_reg != 3'd0;
	assign sticky_set[1] = cmd_done && cmd_full[6] && !dec_map;
	assign sticky_set[0] = write_try && dec_sel == SEL_NONE;
	assign sticky_clr = (cmd_done && cmd_full[6] && cmd_full[5:0] == `CCD_ADDR_FLAGS) ? 4'hF : 4'h0;
	assign raw_flags = (FAULT_IN & ~`CCD_SERIAL_FLAGS) | {17'h0_0000, sticky_reg, 3'h0};
	assign en_mask = {4'h0, |en_reg[20:19], en_reg[18:11], 1'b0, en_reg[9], 1'b0, en_reg[7:0]};
	assign vis_flags = raw_flags & en_mask & `CCD_FLAGS_VALID;
	always @(posedge MCLK) begin
		if (!RST_N) begin
			sticky_reg <= 4'h0;
			flag_reg <= `CCD_FLAGS_RST;
			ERROR_FLAG <= 1'b0;
			tally_reg <= `CCD_TALLY_RST;
		end else begin
			sticky_reg <= (sticky_reg & ~sticky_clr) | sticky_set;
			flag_reg <= vis_flags;
			ERROR_FLAG <= |vis_flags;
			if (en_reg[`CCD_EN_TALLY]) begin
				tally_reg <= tally_reg + 8'h01;
			end
		end
	end
endmodule // ccd_top

// *** hdl/ccd_defs.vh ***
// Register map, field positions, reset values and timing for the converter control block
`ifndef CCD_DEFS_VH
`define CCD_DEFS_VH

`define CCD_ADDR_STATUS 6'h00
`define CCD_ADDR_CONTROL 6'h01
`define CCD_ADDR_FLAGS 6'h06
`define CCD_ADDR_ENABLES 6'h07
`define CCD_ADDR_TALLY 6'h08
`define CCD_ADDR_CHAN_BASE 6'h09
`define CCD_ADDR_CHAN_LAST 6'h18
`define CCD_ADDR_CONFIG_BASE 6'h19
`define CCD_ADDR_CONFIG_LAST 6'h20
`define CCD_ADDR_OFFSET_BASE 6'h29
`define CCD_ADDR_OFFSET_LAST 6'h30
`define CCD_ADDR_GAIN_BASE 6'h31
`define CCD_ADDR_GAIN_LAST 6'h38

`define CCD_CONTROL_RST 16'h0000
`define CCD_FLAGS_RST 24'h00_0000
`define CCD_ENABLES_RST 24'h00_0040
`define CCD_TALLY_RST 8'h00
`define CCD_CHAN_RST 16'h0000
`define CCD_CONFIG_RST 16'h0860
`define CCD_OFFSET_RST 24'h80_0000
`define CCD_GAIN_RST 24'h50_0000

`define CCD_CONTROL_WMASK 16'h1FFF
`define CCD_ENABLES_WMASK 24'h7F_FFFF
`define CCD_FLAGS_VALID 24'h0F_FAFF
`define CCD_CHAN_WMASK 16'hF3FF
`define CCD_CONFIG_WMASK 16'h0FFF
`define CCD_SERIAL_FLAGS 24'h00_0078

`define CCD_CTL_CLK_LO 0
`define CCD_CTL_MODE_LO 2
`define CCD_CTL_POWER_LO 6
`define CCD_CTL_REF_EN 8
`define CCD_CTL_CS_EN 9
`define CCD_CTL_DATA_STATUS 10
`define CCD_CTL_CONTINUOUS_READOUT 11
`define CCD_CTL_RDY_DEL 12
`define CCD_CFG_REF_LO 3
`define CCD_CHAN_EN 15
`define CCD_CHAN_SETUP_LO 12
`define CCD_EN_TALLY 22

`define CCD_MODE_CONT 4'h0
`define CCD_MODE_SINGLE 4'h1
`define CCD_MODE_STANDBY 4'h2
`define CCD_MODE_POWERDOWN 4'h3
`define CCD_MODE_IDLE 4'h4
`define CCD_MODE_INT_ZERO 4'h5
`define CCD_MODE_INT_FULL 4'h6
`define CCD_MODE_SYS_ZERO 4'h7
`define CCD_MODE_SYS_FULL 4'h8

`define CCD_CLK_PERIOD_NS 4
`define CCD_BOOT_NS 2000
`define CCD_BOOT_CYCLES ((`CCD_BOOT_NS + `CCD_CLK_PERIOD_NS - 1) / `CCD_CLK_PERIOD_NS)

`endif

// *** hdl/ccd_serial_port.v ***
// Pin synchroniser and edge finder for the serial register port
`timescale 1ns/1ns
module ccd_serial_port (
	// System
	input wire clk,
	input wire rst_n,
	// Pins
	input wire sclk,
	input wire cs_n,
	input wire din,
	// Events
	output reg rise,
	output reg fall,
	output wire din_f,
	output wire cs_act,
	output reg frame_end
);
	wire [2:0] pin_in;
	reg [2:0] s1_reg;
	reg [2:0] s2_reg;
	reg [2:0] s3_reg;
	reg [2:0] filt_reg;
	assign pin_in = {din, cs_n, sclk};
	assign din_f = filt_reg[2];
	assign cs_act = ~filt_reg[1];
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_sync
			// Idle levels: clock and select high
			localparam IDLE = (i < 2) ? 1'b1 : 1'b0;
			always @(posedge clk) begin
				if (!rst_n) begin
					s1_reg[i] <= IDLE;
					s2_reg[i] <= IDLE;
					s3_reg[i] <= IDLE;
					filt_reg[i] <= IDLE;
				end else begin
					s1_reg[i] <= pin_in[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					if (s2_reg[i] == s3_reg[i]) begin
						filt_reg[i] <= s3_reg[i];
					end
				end
			end
		end
	endgenerate
	always @(posedge clk) begin
		if (!rst_n) begin
			rise <= 1'b0;
			fall <= 1'b0;
			frame_end <= 1'b0;
		end else begin
			rise <= (s2_reg[0] == s3_reg[0]) && s3_reg[0] && !filt_reg[0];
			fall <= (s2_reg[0] == s3_reg[0]) && !s3_reg[0] && filt_reg[0];
			frame_end <= (s2_reg[1] == s3_reg[1]) && s3_reg[1] && !filt_reg[1];
		end
	end
endmodule // ccd_serial_port

// *** hdl/ccd_sequencer.v ***
// Channel registers and ascending wrap-around channel sequencer
`timescale 1ns/1ns
`include "ccd_defs.vh"
module ccd_sequencer #(
	parameter CHANNELS = 16
) (
	// System
	input wire clk,
	input wire rst_n,
	// Register access
	input wire wr_en,
	input wire [3:0] wr_idx,
	input wire [15:0] wr_data,
	input wire [3:0] rd_idx,
	output wire [15:0] rd_data,
	// Sequencing
	input wire advance,
	output reg [3:0] cur_chan,
	output wire [15:0] cur_word,
	output wire any_en
);
	reg [16*CHANNELS-1:0] chan_all;
	wire [CHANNELS-1:0] en_vec;
	reg [3:0] nxt;
	reg [3:0] step;
	reg found;
	integer k;
	genvar c;
	generate
		for (c = 0; c < CHANNELS; c = c + 1) begin : g_chan
			localparam [3:0] IDX = c;
			assign en_vec[c] = chan_all[16*c+`CCD_CHAN_EN];
			always @(posedge clk) begin
				if (!rst_n) begin
					chan_all[16*c +: 16] <= `CCD_CHAN_RST;
				end else if (wr_en && wr_idx == IDX) begin
					chan_all[16*c +: 16] <= wr_data & `CCD_CHAN_WMASK;
				end
			end
		end
	endgenerate
	assign rd_data = chan_all[16*rd_idx +: 16];
	assign cur_word = chan_all[16*cur_chan +: 16];
	assign any_en = |en_vec;
	// Next enabled channel above current, wrapping to lowest
	always @* begin
		nxt = cur_chan;
		step = cur_chan;
		found = 1'b0;
		for (k = 0; k < CHANNELS; k = k + 1) begin
			step = step + 4'h1;
			if (!found && en_vec[step]) begin
				nxt = step;
				found = 1'b1;
			end
		end
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			cur_chan <= 4'h0;
		end else if (advance) begin
			cur_chan <= nxt;
		end
	end
endmodule // ccd_sequencer

// *** verif/ccd_top_props.sv ***
// Concurrent checks on the converter control block ports
`timescale 1ns/1ns
module ccd_top_props (
	// System
	input wire MCLK,
	input wire RST_N,
	// Serial port
	input wire CS_N,
	input wire DOUT_OE,
	// Core settings
	input wire [1:0] POWER_LEVEL,
	input wire [3:0] OP_MODE,
	input wire [1:0] CLK_SOURCE,
	input wire REF_ENABLE,
	input wire CS_GATE_EN,
	input wire APPEND_STATUS,
	input wire CONT_READOUT,
	input wire OUTPUT_READY_DELAY,
	// Conversion link
	input wire CONV_START,
	input wire [3:0] CONV_MODE,
	input wire [3:0] CONV_CHANNEL,
	input wire [2:0] CONV_SETUP,
	input wire [1:0] CONV_REF_SOURCE,
	input wire [23:0] CONV_OFFSET,
	input wire [23:0] CONV_GAIN,
	input wire CONV_DONE
);
	reg busy_reg;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Conversion in flight
	always @(posedge MCLK) begin
		if (!RST_N)
			busy_reg <= 1'b0;
		else if (CONV_START)
			busy_reg <= 1'b1;
		else if (CONV_DONE)
			busy_reg <= 1'b0;
	end
	property p_start_pulse; CONV_START |=> !CONV_START; endproperty
	property p_start_mode; CONV_START |-> CONV_MODE inside {4'h0, 4'h1, [4'h5:4'h8]}; endproperty
	property p_conv_hold;
		!CONV_START |-> $stable({CONV_MODE, CONV_CHANNEL, CONV_SETUP, CONV_REF_SOURCE, CONV_OFFSET, CONV_GAIN});
	endproperty
	property p_cal_idle; busy_reg && CONV_DONE && CONV_MODE inside {4'h1, [4'h5:4'h8]} |=> OP_MODE == 4'h4; endproperty
	property p_gap; busy_reg && CONV_DONE |=> !CONV_START; endproperty
	property p_cont_restart;
		busy_reg && CONV_DONE && CONV_MODE == 4'h0 ##2 OP_MODE == 4'h0 |-> ##[0:38] CONV_START;
	endproperty
	property p_oe_on; !CS_N [*8] |-> DOUT_OE; endproperty
	property p_oe_off; CS_N [*8] |-> !DOUT_OE; endproperty
	property p_host_settings;
		!$stable({POWER_LEVEL, CLK_SOURCE, REF_ENABLE, CS_GATE_EN, APPEND_STATUS, CONT_READOUT, OUTPUT_READY_DELAY})
			|-> DOUT_OE;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
	a_start_mode: assert property (p_start_mode) else $error("start in a non-converting mode");
	a_conv_hold: assert property (p_conv_hold) else $error("request fields moved without start");
	a_cal_idle: assert property (p_cal_idle) else $error("mode not idle after one-shot");
	a_gap: assert property (p_gap) else $error("start right after done");
	a_cont_restart: assert property (p_cont_restart) else $error("continuous run stalled");
	a_oe_on: assert property (p_oe_on) else $error("output not enabled in frame");
	a_oe_off: assert property (p_oe_off) else $error("output enabled outside frame");
	a_host_settings: assert property (p_host_settings) else $error("settings moved outside frame");
	c_cal: cover property (CONV_START && CONV_MODE == 4'h5);
	c_done: cover property (busy_reg && CONV_DONE);
	c_frame: cover property ($rose(DOUT_OE));
endmodule // ccd_top_props

bind ccd_top ccd_top_props u_props (.MCLK(MCLK), .RST_N(RST_N), .CS_N(CS_N), .DOUT_OE(DOUT_OE),
	.POWER_LEVEL(POWER_LEVEL), .OP_MODE(OP_MODE), .CLK_SOURCE(CLK_SOURCE), .REF_ENABLE(REF_ENABLE),
	.CS_GATE_EN(CS_GATE_EN), .APPEND_STATUS(APPEND_STATUS), .CONT_READOUT(CONT_READOUT),
	.OUTPUT_READY_DELAY(OUTPUT_READY_DELAY), .CONV_START(CONV_START), .CONV_MODE(CONV_MODE),
	.CONV_CHANNEL(CONV_CHANNEL), .CONV_SETUP(CONV_SETUP), .CONV_REF_SOURCE(CONV_REF_SOURCE),
	.CONV_OFFSET(CONV_OFFSET), .CONV_GAIN(CONV_GAIN), .CONV_DONE(CONV_DONE));

// *** verif/ccd_host_model.sv ***
// Host serial controller model driving the register port
`timescale 1ns/1ns
module ccd_host_model (
	// Clock
	input wire mclk,
	// Serial pins
	output reg sclk,
	output reg cs_n,
	output reg din,
	input wire dout
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// Command byte then n data bits, MSB first; 64 ns link clock
	task xfer(input [7:0] cmd, input [23:0] wdat, input integer n, output [23:0] rdat);
		reg [31:0] sh;
		integer k;
		begin
			sh = {cmd, wdat << (24 - n)};
			rdat = 24'h00_0000;
			@(posedge mclk) cs_n <= 1'b0;
			for (k = 0; k < 8 + n; k = k + 1) begin
				repeat (8) @(posedge mclk);
				sclk <= 1'b0;
				din <= sh[31 - k];
				repeat (8) @(posedge mclk);
				if (k >= 8)
					rdat = {rdat[22:0], dout};
				sclk <= 1'b1;
			end
			repeat (8) @(posedge mclk);
			cs_n <= 1'b1;
			// Released line must not keep the last bit
			din <= ~din;
			repeat (16) @(posedge mclk);
		end
	endtask
endmodule // ccd_host_model

// *** verif/converter_control_and_diagnostics_tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module converter_control_and_diagnostics_tb;
	localparam [23:0] GAIN_RST = 24'h5A_5A5A;
	reg MCLK = 1'b0;
	reg RST_N = 1'b0;
	reg CONV_DONE = 1'b0;
	reg [23:0] CAL_VALUE = 24'h12_3456;
	reg [23:0] FAULT_IN = 24'h00_0000;
	wire SCLK, CS_N, DIN, DOUT, DOUT_OE, REF_ENABLE, CS_GATE_EN, APPEND_STATUS, CONT_READOUT;
	wire OUTPUT_READY_DELAY, CONV_START, ERROR_FLAG;
	wire [1:0] POWER_LEVEL, CLK_SOURCE, CONV_REF_SOURCE;
	wire [3:0] OP_MODE, CONV_MODE, CONV_CHANNEL;
	wire [4:0] CONV_POS, CONV_NEG;
	wire [2:0] CONV_SETUP;
	wire [23:0] CONV_OFFSET, CONV_GAIN;
	integer mismatches = 0;
	integer cmp_count = 0;
	integer cycles = 0;
	integer i;
	reg [4:0] done_cnt = 5'd0;
	reg logging = 1'b0;
	reg [18:0] log_q[$];
	reg [23:0] t1, t2;
	always #2 MCLK = ~MCLK;
	ccd_host_model host (.mclk(MCLK), .sclk(SCLK), .cs_n(CS_N), .din(DIN), .dout(DOUT));
	ccd_top #(.BOOT_CYCLES(1500), .GAIN_RESET(GAIN_RST)) DUT (.MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK),
		.CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .POWER_LEVEL(POWER_LEVEL), .OP_MODE(OP_MODE),
		.CLK_SOURCE(CLK_SOURCE), .REF_ENABLE(REF_ENABLE), .CS_GATE_EN(CS_GATE_EN), .APPEND_STATUS(APPEND_STATUS),
		.CONT_READOUT(CONT_READOUT), .OUTPUT_READY_DELAY(OUTPUT_READY_DELAY), .CONV_START(CONV_START),
		.CONV_MODE(CONV_MODE), .CONV_CHANNEL(CONV_CHANNEL), .CONV_POS(CONV_POS), .CONV_NEG(CONV_NEG),
		.CONV_SETUP(CONV_SETUP), .CONV_REF_SOURCE(CONV_REF_SOURCE), .CONV_OFFSET(CONV_OFFSET),
		.CONV_GAIN(CONV_GAIN), .CONV_DONE(CONV_DONE), .CAL_VALUE(CAL_VALUE), .FAULT_IN(FAULT_IN),
		.ERROR_FLAG(ERROR_FLAG));
	// Core stand-in answers each start 20 cycles later
	always @(posedge MCLK) begin
		cycles <= cycles + 1;
		if (CONV_START) begin
			done_cnt <= 5'd20;
			if (logging)
				log_q.push_back({CONV_CHANNEL, CONV_SETUP, CONV_REF_SOURCE, CONV_POS, CONV_NEG});
		end else if (done_cnt != 5'd0)
			done_cnt <= done_cnt - 5'd1;
		CONV_DONE <= (done_cnt == 5'd1);
	end
	always @(posedge MCLK) if (cycles == 60000) begin
		mismatches = mismatches + 1;
		finish_test;
	end
	task chk(input [23:0] got, input [23:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rd(input [7:0] a, input integer n, input [23:0] exp);
		reg [23:0] v;
		begin
			host.xfer(8'h40 | a, 24'h00_0000, n, v);
			chk(v, exp);
		end
	endtask
	task wr(input [7:0] a, input integer n, input [23:0] d);
		reg [23:0] v;
		begin
			host.xfer(a, d, n, v);
		end
	endtask
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
			if (mismatches == 0 && cmp_count > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		repeat (4) @(posedge MCLK);
		RST_N <= 1'b1;
		rd(8'h06, 24, 24'h00_0000);
		wr(8'h01, 16, 24'h00_0044);
		rd(8'h01, 16, 24'h00_0000);
		rd(8'h07, 24, 24'h00_0040);
		rd(8'h08, 8, 24'h00_0000);
		repeat (1500) @(posedge MCLK);
		rd(8'h06, 24, 24'h00_0040);
		rd(8'h06, 24, 24'h00_0000);
		$display("test reset and boot done");
		for (i = 0; i <= 8; i = i + 1) begin
			t1 = 24'h00_E000 | (i << 8) | ((i % 3) << 6) | (i << 2) | (i % 4);
			wr(8'h01, 16, t1);
			rd(8'h01, 16, t1 & 24'h00_1FFF);
			chk({POWER_LEVEL, OP_MODE, CLK_SOURCE}, ((i % 3) << 6) | (i << 2) | (i % 4));
			chk({OUTPUT_READY_DELAY, CONT_READOUT, APPEND_STATUS, CS_GATE_EN, REF_ENABLE}, i);
		end
		wr(8'h01, 16, 24'h00_0010);
		$display("test control fields done");
		@(posedge MCLK) FAULT_IN <= 24'hFF_FF07;
		wr(8'h07, 24, 24'hFF_FFFF);
		rd(8'h07, 24, 24'h7F_FFFF);
		rd(8'h06, 24, 24'h0F_FA07);
		chk(ERROR_FLAG, 24'h00_0001);
		rd(8'h00, 8, 24'h00_00C0);
		wr(8'h07, 24, 24'h00_0000);
		rd(8'h06, 24, 24'h00_0000);
		chk(ERROR_FLAG, 24'h00_0000);
		rd(8'h00, 8, 24'h00_0080);
		wr(8'h07, 24, 24'h00_00FF);
		wr(8'h08, 8, 24'h00_0055);
		rd(8'h02, 8, 24'h00_0000);
		wr(8'h01, 5, 24'h00_0015);
		rd(8'h06, 24, 24'h00_003F);
		wr(8'h07, 24, 24'h40_0000);
		host.xfer(8'h48, 24'h00_0000, 8, t1);
		// Back-to-back 8-bit reads sample the tally 281 cycles apart
		rd(8'h08, 8, (t1 + 24'd25) & 24'h00_00FF);
		wr(8'h07, 24, 24'h00_0000);
		host.xfer(8'h48, 24'h00_0000, 8, t2);
		rd(8'h08, 8, t2);
		$display("test diagnostics done");
		@(posedge MCLK) FAULT_IN <= 24'h00_0000;
		wr(8'h0A, 16, 24'h00_A062);
		wr(8'h0C, 16, 24'h00_D0E6);
		wr(8'h1E, 16, 24'h00_0870);
		rd(8'h0A, 16, 24'h00_A062);
		logging <= 1'b1;
		wr(8'h01, 16, 24'h00_0000);
		for (i = 0; i < 4000 && log_q.size() < 4; i = i + 1) @(posedge MCLK);
		wr(8'h01, 16, 24'h00_0010);
		for (i = 0; i < 4; i = i + 1)
			chk(log_q[i], (i % 2) ? {4'd3, 3'd5, 2'd2, 5'd7, 5'd6} : {4'd1, 3'd2, 2'd0, 5'd3, 5'd2});
		chk(CONV_OFFSET, 24'h80_0000);
		chk(CONV_GAIN, GAIN_RST);
		$display("test sequencer done");
		wr(8'h0A, 16, 24'h00_0000);
		wr(8'h01, 16, 24'h00_0014);
		for (i = 0; i < 4000 && OP_MODE !== 4'h4; i = i + 1) @(posedge MCLK);
		chk({CONV_MODE, CONV_CHANNEL, OP_MODE}, 24'h00_0534);
		rd(8'h2E, 24, 24'h12_3456);
		@(posedge MCLK) CAL_VALUE <= 24'h65_4321;
		wr(8'h01, 16, 24'h00_0020);
		for (i = 0; i < 4000 && OP_MODE !== 4'h4; i = i + 1) @(posedge MCLK);
		rd(8'h36, 24, 24'h65_4321);
		rd(8'h2B, 24, 24'h80_0000);
		$display("test calibration done");
		finish_test;
	end
endmodule // converter_control_and_diagnostics_tb
